//--- logic/mrc_consts.vh
/*
 * Constants of the Modbus RTU master response checker: result codes,
 * limits, checksum parameters and timing.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef MRC_CONSTS_VH
`define MRC_CONSTS_VH

`define MRC_RES_OK          16'h0000
`define MRC_RES_BAD_ADDR    16'h286e
`define MRC_RES_BAD_QLEN    16'h286f
`define MRC_RES_RSP_SPACE   16'h2870
`define MRC_RES_CRC         16'h2871
`define MRC_RES_SLAVE       16'h2872
`define MRC_RES_FUNC        16'h2873
`define MRC_RES_CHAR        16'h2874
`define MRC_RES_LATE        16'h2875
`define MRC_RES_OVERRUN     16'h2877

`define MRC_QLEN_MAX        8'hfc
`define MRC_EXC_BIT         8'h80
`define MRC_CRC_INIT        16'hffff
`define MRC_CRC_POLY        16'ha001

`define MRC_CLK_HZ          50000000
`define MRC_ICG_US          750
`define MRC_ICG_CYC         ((`MRC_CLK_HZ / 1000000) * `MRC_ICG_US)

`endif

//--- logic/mrc_checker.v
/*
 * Modbus RTU master response checker: validates the command block before a
 * query is sent and checks each response frame, storing address and
 * function code words and reporting one result code per command.
 * Assumes a receiver on the same clock delivering bytes with per-character
 * parity, framing and overrun flags, and an end-of-frame pulse from the
 * silent-interval detector.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mrc_consts.vh"

module mrc_checker #(
    parameter        AW      = 16,
    parameter [31:0] ICG_CYC = `MRC_ICG_CYC
) (
    input  wire          clk,
    input  wire          resetn,
    input  wire          cmd_valid,
    input  wire [AW-1:0] cmd_qaddr,
    input  wire [7:0]    cmd_qlen,
    input  wire [AW-1:0] cmd_raddr,
    input  wire [7:0]    cmd_rwords,
    input  wire [7:0]    cmd_slave,
    input  wire [7:0]    cmd_func,
    output wire          cmd_ready,
    output reg           query_go_r,
    input  wire          query_done,
    input  wire          rx_valid,
    input  wire [7:0]    rx_data,
    input  wire          rx_parity_err,
    input  wire          rx_frame_err,
    input  wire          rx_overrun,
    input  wire          rx_eof,
    output reg           mem_we_r,
    output reg  [AW-1:0] mem_addr_r,
    output reg  [15:0]   mem_wdata_r,
    output reg           res_valid_r,
    output reg  [15:0]   res_code_r
);

    // ****************************************************************
    // State
    // ****************************************************************
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SEND = 4'b0010;
    localparam [3:0] ST_RECV = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;

    reg  [3:0]    state_r;
    reg  [AW-1:0] raddr_r;
    reg  [7:0]    rwords_r;
    reg  [7:0]    slave_r;
    reg  [7:0]    func_r;
    reg  [8:0]    nbytes_r;
    reg  [7:0]    b0_r;
    reg  [7:0]    b1_r;
    reg  [7:0]    last1_r;
    reg  [7:0]    last2_r;
    reg  [15:0]   crc_r;
    reg  [15:0]   crc_hold1_r;
    reg  [15:0]   crc_hold2_r;
    reg  [31:0]   gap_r;
    reg  [15:0]   err_r;
    reg  [15:0]   err_nxt;
    reg  [15:0]   crc_nxt;

    // ****************************************************************
    // Command handshake
    // ****************************************************************
    // Commands are refused while a query or its reply is in flight; the
    // host keeps cmd_valid up until the block is back in idle.
    assign cmd_ready = (state_r == ST_IDLE);

    // ****************************************************************
    // Command checks
    // ****************************************************************
    // A response area is mandatory because the address and function word
    // is stored even when the reply carries no data.
    wire          cmd_raddr_zero;
    wire          cmd_qaddr_bad;
    wire          cmd_qlen_bad;

    assign cmd_raddr_zero = (cmd_raddr == {AW{1'b0}});
    assign cmd_qaddr_bad  = (cmd_qaddr == {AW{1'b0}}) && (cmd_qlen != 8'h00);
    assign cmd_qlen_bad   = (cmd_qlen > `MRC_QLEN_MAX);

    // ****************************************************************
    // Checksum
    // ****************************************************************
    // One shift stage per bit of the incoming byte; the chain settles in
    // one cycle, so the running value keeps in step with rx_valid.
    wire [15:0]   crc_stage [0:8];

    assign crc_stage[0] = crc_r ^ {8'h00, rx_data};

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_crc_bit
            assign crc_stage[g+1] = crc_stage[g][0] ?
                                    ((crc_stage[g] >> 1) ^ `MRC_CRC_POLY) :
                                    (crc_stage[g] >> 1);
        end
    endgenerate

    always @* begin
        crc_nxt = crc_stage[8];
    end

    // ****************************************************************
    // Per-character conditions
    // ****************************************************************
    // The first character is exempt from the gap check: the pause before
    // it is the slave's turnaround, not an inter-character gap.
    wire          byte_first;
    wire          byte_second;
    wire          char_bad;
    wire          char_late;
    wire          slave_bad;
    wire          func_bad;

    assign byte_first  = (nbytes_r == 9'h000);
    assign byte_second = (nbytes_r == 9'h001);
    assign char_bad    = rx_valid && (rx_parity_err || rx_frame_err);
    assign char_late   = rx_valid && !byte_first && (gap_r >= ICG_CYC);
    assign slave_bad   = rx_valid && byte_first && (rx_data != slave_r);
    assign func_bad    = rx_valid && byte_second && (rx_data != func_r) &&
                         (rx_data != (func_r | `MRC_EXC_BIT));

    // ****************************************************************
    // Frame-end conditions
    // ****************************************************************
    // The area holds one word for address and function plus the data
    // bytes packed two to a word; an odd last byte still needs a word.
    wire          frame_short;
    wire          crc_bad;
    wire [8:0]    words_need;
    wire          space_bad;

    assign frame_short = (nbytes_r < 9'h004);
    assign crc_bad     = frame_short || (crc_hold2_r != {last1_r, last2_r});
    assign words_need  = ((nbytes_r - 9'h003) >> 1) + 9'h001;
    assign space_bad   = (words_need > {1'b0, rwords_r});

    // ****************************************************************
    // Per-character checks
    // ****************************************************************
    // Only the first failure of a frame is kept, so the reported code
    // names the earliest fault rather than the last.
    always @* begin
        err_nxt = err_r;
        if (err_r == `MRC_RES_OK) begin
            // Overrun is taken in any cycle, not only beside a character,
            // because the lost byte never shows up as rx_valid.
            if (rx_overrun) begin
                err_nxt = `MRC_RES_OVERRUN;
            end else if (char_bad) begin
                err_nxt = `MRC_RES_CHAR;
            end else if (char_late) begin
                err_nxt = `MRC_RES_LATE;
            end else if (slave_bad) begin
                err_nxt = `MRC_RES_SLAVE;
            end else if (func_bad) begin
                err_nxt = `MRC_RES_FUNC;
            end
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r     <= ST_IDLE;
            raddr_r     <= {AW{1'b0}};
            rwords_r    <= 8'h00;
            slave_r     <= 8'h00;
            func_r      <= 8'h00;
            nbytes_r    <= 9'h000;
            b0_r        <= 8'h00;
            b1_r        <= 8'h00;
            last1_r     <= 8'h00;
            last2_r     <= 8'h00;
            crc_r       <= `MRC_CRC_INIT;
            crc_hold1_r <= `MRC_CRC_INIT;
            crc_hold2_r <= `MRC_CRC_INIT;
            gap_r       <= 32'h0000_0000;
            err_r       <= `MRC_RES_OK;
            query_go_r  <= 1'b0;
            mem_we_r    <= 1'b0;
            mem_addr_r  <= {AW{1'b0}};
            mem_wdata_r <= 16'h0000;
            res_valid_r <= 1'b0;
            res_code_r  <= `MRC_RES_OK;
        end else begin
            query_go_r  <= 1'b0;
            mem_we_r    <= 1'b0;
            res_valid_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        raddr_r  <= cmd_raddr;
                        rwords_r <= cmd_rwords;
                        slave_r  <= cmd_slave;
                        func_r   <= cmd_func;
                        if (cmd_raddr_zero) begin
                            res_code_r  <= `MRC_RES_BAD_ADDR;
                            res_valid_r <= 1'b1;
                        end else if (cmd_qaddr_bad) begin
                            res_code_r  <= `MRC_RES_BAD_ADDR;
                            res_valid_r <= 1'b1;
                        end else if (cmd_qlen_bad) begin
                            res_code_r  <= `MRC_RES_BAD_QLEN;
                            res_valid_r <= 1'b1;
                        end else begin
                            query_go_r <= 1'b1;
                            state_r    <= ST_SEND;
                        end
                    end
                end
                ST_SEND: begin
                    // Clearing the captured bytes here keeps an empty reply
                    // from writing the address word of an earlier frame.
                    nbytes_r <= 9'h000;
                    b0_r     <= 8'h00;
                    b1_r     <= 8'h00;
                    crc_r    <= `MRC_CRC_INIT;
                    gap_r    <= 32'h0000_0000;
                    err_r    <= `MRC_RES_OK;
                    if (query_done) begin
                        state_r <= ST_RECV;
                    end
                end
                ST_RECV: begin
                    err_r <= err_nxt;
                    // The gap counter stops at its top value instead of
                    // wrapping, so a very long pause never reads as short.
                    if (gap_r != 32'hffff_ffff) begin
                        gap_r <= gap_r + 32'h0000_0001;
                    end
                    if (rx_valid) begin
                        gap_r       <= 32'h0000_0000;
                        crc_r       <= crc_nxt;
                        crc_hold1_r <= crc_r;
                        crc_hold2_r <= crc_hold1_r;
                        last2_r     <= last1_r;
                        last1_r     <= rx_data;
                        if (nbytes_r != 9'h1ff) begin
                            nbytes_r <= nbytes_r + 9'h001;
                        end
                        if (nbytes_r == 9'h000) begin
                            b0_r <= rx_data;
                        end
                        if (nbytes_r == 9'h001) begin
                            b1_r <= rx_data;
                        end
                    end
                    if (rx_eof) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // The checksum before the two trailing bytes covers
                    // address, function and data only.
                    if (err_r != `MRC_RES_OK) begin
                        res_code_r <= err_r;
                    end else if (crc_bad) begin
                        res_code_r <= `MRC_RES_CRC;
                    end else if (space_bad) begin
                        res_code_r <= `MRC_RES_RSP_SPACE;
                    end else begin
                        res_code_r <= `MRC_RES_OK;
                    end
                    // The word is written whatever the verdict, so the host
                    // can see who answered even for an exception reply.
                    mem_we_r    <= 1'b1;
                    mem_addr_r  <= raddr_r;
                    mem_wdata_r <= {b0_r, b1_r};
                    res_valid_r <= 1'b1;
                    state_r     <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

//--- test/mrc_checker_sva.sv
/* Port assertions for mrc_checker. Assumes it is bound to every instance. */
`timescale 1ns/1ps
`default_nettype none
`include "mrc_consts.vh"
module mrc_checker_sva #(
    parameter AW = 16
) (
    input wire logic          clk,
    input wire logic          resetn,
    input wire logic          cmd_valid,
    input wire logic          cmd_ready,
    input wire logic [AW-1:0] cmd_qaddr,
    input wire logic [7:0]    cmd_qlen,
    input wire logic [AW-1:0] cmd_raddr,
    input wire logic          query_go_r,
    input wire logic          query_done,
    input wire logic          rx_eof,
    input wire logic          mem_we_r,
    input wire logic [AW-1:0] mem_addr_r,
    input wire logic          res_valid_r,
    input wire logic [15:0]   res_code_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire acc = cmd_valid && cmd_ready;
    // A result that is not valid reads as a code that no check produces.
    wire [15:0] res = res_valid_r ? res_code_r : 16'h0001;
    logic          recv_r;
    logic [AW-1:0] raddr_r;
    always_ff @(posedge clk or negedge resetn)
        if (!resetn) {recv_r, raddr_r} <= '0;
        else begin
            if (acc) raddr_r <= cmd_raddr;
            if (query_done || rx_eof) recv_r <= query_done && !cmd_ready;
        end
    a_zero_resp: assert property (acc && cmd_raddr == 0 |=> res == `MRC_RES_BAD_ADDR)
        else $error("zero response location taken");
    a_zero_go: assert property (acc && cmd_raddr == 0 |=> !query_go_r)
        else $error("query started without response area");
    a_zero_query: assert property (acc && cmd_raddr != 0 && cmd_qaddr == 0
        && cmd_qlen != 0 |=> res == `MRC_RES_BAD_ADDR) else $error("zero query location taken");
    a_long_query: assert property (acc && cmd_raddr != 0 && cmd_qaddr != 0
        && cmd_qlen > `MRC_QLEN_MAX |=> res == `MRC_RES_BAD_QLEN) else $error("long query taken");
    a_query_go: assert property (acc && cmd_raddr != 0 && cmd_qlen <= `MRC_QLEN_MAX
        && (cmd_qaddr != 0 || cmd_qlen == 0) |=> query_go_r && !res_valid_r) else $error("no start");
    a_eof_answer: assert property (recv_r && rx_eof |-> ##2 mem_we_r && res_valid_r)
        else $error("no word or result after frame end");
    a_word_addr: assert property (mem_we_r |-> mem_addr_r == raddr_r)
        else $error("word written outside response area");
    a_word_tie: assert property (mem_we_r |-> res_valid_r)
        else $error("word written without result");
endmodule
bind mrc_checker mrc_checker_sva #(.AW(AW)) i_mrc_checker_sva (.*);
`default_nettype wire

//--- test/mrc_slave.sv
/* Slave model sending one response frame per call. Assumes calls only while receiving. */
`timescale 1ns/1ps
`default_nettype none
module mrc_slave #(
    parameter ICG = 20
) (
    input  wire logic  clk,
    output logic       rx_valid,
    output logic [7:0] rx_data,
    output logic       rx_parity_err,
    output logic       rx_frame_err,
    output logic       rx_overrun,
    output logic       rx_eof
);
    initial {rx_valid, rx_data, rx_parity_err, rx_frame_err, rx_overrun, rx_eof} = '0;
    task automatic put(input logic [7:0] d, input logic [2:0] err, input int gap);
        repeat (gap) @(posedge clk);
        {rx_valid, rx_data, rx_parity_err, rx_frame_err, rx_overrun} <= {1'b1, d, err};
        @(posedge clk);
        // An idle data line shows the inverse of the last byte so stale data never matches.
        {rx_valid, rx_data, rx_parity_err, rx_frame_err, rx_overrun} <= {1'b0, ~d, 3'h0};
    endtask
    task automatic send(input logic [7:0] sl, input logic [7:0] fn, input logic [3:0] kind);
        logic [7:0]  b [6];
        logic [15:0] c;
        b = '{kind == 4'h2 ? sl ^ 8'h01 : sl,
              kind == 4'h3 ? fn + 8'h01 : kind == 4'h4 ? fn | 8'h80 : fn,
              8'h12, 8'h34, 8'h00, 8'h00};
        c = 16'hffff;
        for (int i = 0; i < 4; i++) begin
            c = c ^ {8'h00, b[i]};
            repeat (8)
                c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        b[4] = c[7:0] ^ {7'h00, kind == 4'h1};
        b[5] = c[15:8];
        for (int i = 0; i < 6; i++)
            put(b[i], i == 0 ? {kind == 4'h5, kind == 4'h6, kind == 4'h8} : 3'h0,
                kind == 4'h7 && i == 3 ? ICG : 1);
        repeat (2) @(posedge clk);
        rx_eof <= 1'b1;
        @(posedge clk);
        rx_eof <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/mrc_checker_tb.sv
/* Bench for mrc_checker: table of commands and replies, then refusal and reset. Assumes mrc_slave. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; $display("unexpected at %0t: %h not %h", $time, a, b); end end
module mrc_checker_tb;
    typedef struct packed {logic [7:0] rw; logic [3:0] kind; logic [15:0] code;} mrc_row_t;
    mrc_row_t rows [13] = '{
        '{8'h02, 4'h9, 16'h286e}, '{8'h02, 4'ha, 16'h286e}, '{8'h02, 4'hb, 16'h286f},
        '{8'h02, 4'h0, 16'h0000}, '{8'h01, 4'h0, 16'h2870}, '{8'h02, 4'h1, 16'h2871},
        '{8'h02, 4'h2, 16'h2872}, '{8'h02, 4'h3, 16'h2873}, '{8'h02, 4'h4, 16'h0000},
        '{8'h02, 4'h5, 16'h2874}, '{8'h02, 4'h6, 16'h2874}, '{8'h02, 4'h7, 16'h2875},
        '{8'h02, 4'h8, 16'h2877}};
    int          err_count = 0;
    int          checks_done = 0;
    logic        clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, query_done = 1'b0;
    logic [15:0] cmd_qaddr = 16'h0000, cmd_raddr = 16'h0000;
    logic [7:0]  cmd_qlen = 8'h00, cmd_rwords = 8'h00, cmd_slave = 8'h11, cmd_func = 8'h03;
    logic        cmd_ready, query_go_r, rx_valid, rx_parity_err, rx_frame_err, rx_overrun;
    logic        rx_eof, mem_we_r, res_valid_r;
    logic [7:0]  rx_data;
    logic [15:0] mem_addr_r, mem_wdata_r, res_code_r;
    mrc_checker #(.ICG_CYC(32'd20)) i_mrc_checker (.*);
    mrc_slave #(.ICG(20)) i_mrc_slave (.*);
    always #10 clk = ~clk;
    task automatic close_out();
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmd(input logic [15:0] ra, qa, input logic [7:0] ql, rw);
        @(posedge clk);
        cmd_valid <= 1'b1;
        {cmd_raddr, cmd_qaddr, cmd_qlen, cmd_rwords} <= {ra, qa, ql, rw};
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
    endtask
    // Kinds 9 to b are refused commands; the others send 252 query bytes, the longest allowed.
    task automatic run(input mrc_row_t r);
        cmd(r.kind == 4'h9 ? 16'h0000 : 16'h0100, r.kind == 4'ha ? 16'h0000 : 16'h0040,
            r.kind == 4'hb ? 8'hfd : r.kind == 4'ha ? 8'h04 : 8'hfc, r.rw);
        if (r.kind < 4'h9) begin
            `CHK(query_go_r, 1'b1)
            @(posedge clk);
            query_done <= 1'b1;
            @(posedge clk);
            query_done <= 1'b0;
            i_mrc_slave.send(cmd_slave, cmd_func, r.kind);
            @(posedge clk);
            #1;
            `CHK(mem_we_r, 1'b1)
            `CHK(mem_wdata_r, {r.kind == 4'h2 ? 8'h10 : 8'h11, r.kind == 4'h3 ? 8'h04 : r.kind == 4'h4 ? 8'h83 : 8'h03})
        end
        `CHK(res_valid_r, 1'b1)
        `CHK(res_code_r, r.code)
    endtask
    initial begin
        #100000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i])
            run(rows[i]);
        cmd(16'h0100, 16'h0000, 8'h00, 8'h02);
        `CHK(query_go_r, 1'b1)
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_raddr <= 16'h0000;
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(res_valid_r, 1'b0)
        @(posedge clk);
        resetn <= 1'b0;
        #1;
        `CHK({cmd_ready, query_go_r, res_valid_r, mem_we_r, res_code_r}, {4'h8, 16'h0000})
        @(posedge clk);
        resetn <= 1'b1;
        run(rows[5]);
        close_out();
    end
endmodule
`default_nettype wire
